// [src/pll_clock_synthesizer_control.sv]
// clock synthesizer control: reference select, dividers, outputs and lock
`timescale 1ns/10ps

// Behaviour
// - four reference clock inputs, from pads or the core clock tree
// - two-bit select picks the reference input at run time
// - pre-divider N, multiplier M, post-divider O and per-output divider C
// - internal mode: comparison rate is ref over N, oscillator that times M
// - internal mode: output rate is ref times M over N, O and C, or over N, O and 2 when C is 1
// - local/core mode: oscillator is comparison times M, O, feedback C
// - feedback divider is the divider of clock output zero
// - held in reset while reset input low, runs once it is high
// - three clock outputs for the global clock net
// - lock flag rises on lock and falls on detected loss of lock
// - lock flag holds its value when the reference stops toggling
// - external source mode uses the dedicated external reference pin
// - dynamic source mode picks one of four sources by the select bus
// - core source mode takes the reference from a core generated clock
// - internal, local and core feedback modes are supported
// - M 1..255, N 1..15, O 1/2/4/8, C 1..511 (code 0 gives 256)
// - O is at least 2 whenever more than one output is enabled
// - phase shift allowed only for C of 2, 4 or 6 with listed angles
module pll_clock_synthesizer_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ref_clk_in,
  input wire logic external_ref_pin,
  input wire logic [1:0] ref_select,
  input wire logic synth_reset_n,
  input wire logic fabric_feedback_clk,
  output logic synth_out_clk_a,
  output logic synth_out_clk_b,
  output logic synth_out_clk_c,
  output logic locked
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [8:0] pins_in;
  logic [8:0] meta_q;
  logic [8:0] sync_q;
  assign pins_in = {fabric_feedback_clk, synth_reset_n, ref_select,
                    external_ref_pin, ref_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pins_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic [3:0] ref_sync;
  logic ext_sync;
  logic [1:0] sel_sync;
  logic run;
  logic fb_sync;
  assign ref_sync = sync_q[3:0];
  assign ext_sync = sync_q[4];
  assign sel_sync = sync_q[6:5];
  assign run = sync_q[7];
  assign fb_sync = sync_q[8];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] div_q;
  logic [31:0] outdiv_q [3];
  logic [31:0] period_word;
  logic [3:0] status_word;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic commit;
  logic mapped;
  logic [31:0] rd_d;

  assign access = psel & penable & ~pready_q;
  assign commit = psel & penable & pready_q & pwrite & ~pslverr_q;

  always_comb begin
    mapped = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      pll_synth_pkg::ADDR_CTRL: rd_d = ctrl_q;
      pll_synth_pkg::ADDR_DIV: rd_d = div_q;
      pll_synth_pkg::ADDR_OUTDIV_A: rd_d = outdiv_q[0];
      pll_synth_pkg::ADDR_OUTDIV_B: rd_d = outdiv_q[1];
      pll_synth_pkg::ADDR_OUTDIV_C: rd_d = outdiv_q[2];
      pll_synth_pkg::ADDR_STATUS: rd_d = {28'h000_0000, status_word};
      pll_synth_pkg::ADDR_PERIOD: rd_d = period_word;
      default: mapped = 1'b0;
    endcase
  end

  // one wait state: answer registered in the cycle after the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access;
      pslverr_q <= access & ~mapped;
      if (access) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pll_synth_pkg::CTRL_RESET;
      div_q <= pll_synth_pkg::DIV_RESET;
      outdiv_q[0] <= pll_synth_pkg::OUTDIV_RESET;
      outdiv_q[1] <= pll_synth_pkg::OUTDIV_RESET;
      outdiv_q[2] <= pll_synth_pkg::OUTDIV_RESET;
    end else if (commit) begin
      case (paddr)
        pll_synth_pkg::ADDR_CTRL: ctrl_q <= {25'h000_0000, pwdata[6:0]};
        pll_synth_pkg::ADDR_DIV: div_q <= {18'h0_0000, pwdata[13:0]};
        pll_synth_pkg::ADDR_OUTDIV_A:
          outdiv_q[0] <= {17'h0_0000, pwdata[14:12], 3'h0, pwdata[8:0]};
        pll_synth_pkg::ADDR_OUTDIV_B:
          outdiv_q[1] <= {17'h0_0000, pwdata[14:12], 3'h0, pwdata[8:0]};
        pll_synth_pkg::ADDR_OUTDIV_C:
          outdiv_q[2] <= {17'h0_0000, pwdata[14:12], 3'h0, pwdata[8:0]};
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------------
  // settings, clamped to their legal ranges
  // ----------------------------------------------------------------------
  logic [1:0] src_mode;
  logic [1:0] fb_mode;
  logic [2:0] out_en;
  logic [7:0] m_eff;
  logic [3:0] n_eff;
  logic [3:0] o_eff;
  logic [8:0] c_eff [3];
  logic [19:0] fb_product;
  logic [7:0] mult;
  logic settings_bad;
  logic multi_out;

  assign src_mode = ctrl_q[pll_synth_pkg::CTRL_SRC_LSB +: 2];
  assign fb_mode = ctrl_q[pll_synth_pkg::CTRL_FB_LSB +: 2];
  assign out_en = ctrl_q[pll_synth_pkg::CTRL_EN_LSB +: 3];
  assign multi_out = (out_en[0] & out_en[1]) | (out_en[0] & out_en[2]) |
                     (out_en[1] & out_en[2]);

  always_comb begin
    m_eff = div_q[pll_synth_pkg::DIV_M_LSB +: 8];
    if (m_eff == 8'h00) begin
      m_eff = 8'h01;
    end
    n_eff = div_q[pll_synth_pkg::DIV_N_LSB +: 4];
    if (n_eff == 4'h0) begin
      n_eff = 4'h1;
    end
    case (div_q[pll_synth_pkg::DIV_O_LSB +: 2])
      2'h1: o_eff = 4'h2;
      2'h2: o_eff = 4'h4;
      2'h3: o_eff = 4'h8;
      default: o_eff = multi_out ? 4'h2 : 4'h1;
    endcase
  end

  generate
    for (gi = 0; gi < 3; gi++) begin : g_ceff
      // divider code 0 counts as 256; the 9-bit field takes codes up to 511
      assign c_eff[gi] = (outdiv_q[gi][8:0] == 9'h000) ? 9'h100 :
                         outdiv_q[gi][8:0];
    end
  endgenerate

  assign fb_product = {12'h000, m_eff} * {16'h0000, o_eff} *
                      {11'h000, c_eff[0]};

  always_comb begin
    settings_bad = 1'b0;
    if (fb_mode == pll_synth_pkg::FB_INTERNAL) begin
      mult = m_eff;
    end else if (fb_product > {12'h000, pll_synth_pkg::FEEDBACK_PRODUCT_MAX})
    begin
      mult = pll_synth_pkg::FEEDBACK_PRODUCT_MAX;
      settings_bad = 1'b1;
    end else begin
      mult = fb_product[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // reference source and pre-divider
  // ----------------------------------------------------------------------
  logic ref_now;
  logic ref_prev_q;
  logic fb_prev_q;
  logic ref_rise;
  logic [3:0] ndiv_q;
  logic pfd_tick;

  always_comb begin
    case (src_mode)
      pll_synth_pkg::SRC_EXTERNAL: ref_now = ext_sync;
      pll_synth_pkg::SRC_DYNAMIC: ref_now = ref_sync[sel_sync];
      pll_synth_pkg::SRC_CORE:
        ref_now = ref_sync[pll_synth_pkg::CORE_REF_INDEX];
      default: ref_now = ext_sync;
    endcase
  end

  assign ref_rise = ref_now & ~ref_prev_q;
  assign pfd_tick = ref_rise && (ndiv_q >= n_eff - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
      fb_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_now;
      fb_prev_q <= fb_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ndiv_q <= 4'h0;
    end else if (!run) begin
      ndiv_q <= 4'h0;
    end else if (pfd_tick) begin
      ndiv_q <= 4'h0;
    end else if (ref_rise) begin
      ndiv_q <= ndiv_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // comparison period measurement
  // ----------------------------------------------------------------------
  logic [15:0] per_cnt_q;
  logic [15:0] period_q;
  logic ref_stopped;
  logic period_match;

  assign ref_stopped = per_cnt_q >= pll_synth_pkg::REF_STOP_CYCLES;
  assign period_match = (per_cnt_q == period_q) ||
                        (per_cnt_q == period_q + 16'h0001) ||
                        (per_cnt_q + 16'h0001 == period_q);
  assign period_word = {16'h0000, period_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= 16'h0000;
      period_q <= 16'h0000;
    end else if (!run) begin
      per_cnt_q <= 16'h0000;
      period_q <= 16'h0000;
    end else if (pfd_tick) begin
      per_cnt_q <= 16'h0001;
      period_q <= per_cnt_q;
    end else if (per_cnt_q != 16'hFFFF) begin
      per_cnt_q <= per_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // lock detection
  // ----------------------------------------------------------------------
  pll_synth_pkg::lock_state_type lock_state_q;
  logic [3:0] match_q;
  logic fb_seen_q;
  logic loop_ok;
  logic locked_q;

  // core feedback mode also needs the fabric feedback clock to toggle
  assign loop_ok = period_match && !settings_bad &&
                   (fb_mode != pll_synth_pkg::FB_CORE || fb_seen_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_seen_q <= 1'b0;
    end else if (!run) begin
      fb_seen_q <= 1'b0;
    end else if (fb_sync & ~fb_prev_q) begin
      // an edge on the tick itself counts for the next interval
      fb_seen_q <= 1'b1;
    end else if (pfd_tick) begin
      fb_seen_q <= 1'b0;
    end
  end

  // no comparison ticks while the reference stands still, so state holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_state_q <= pll_synth_pkg::ST_UNLOCKED;
      match_q <= 4'h0;
    end else if (!run) begin
      lock_state_q <= pll_synth_pkg::ST_UNLOCKED;
      match_q <= 4'h0;
    end else if (pfd_tick) begin
      case (lock_state_q)
        pll_synth_pkg::ST_UNLOCKED: begin
          lock_state_q <= pll_synth_pkg::ST_ACQUIRE;
          match_q <= 4'h0;
        end
        pll_synth_pkg::ST_ACQUIRE: begin
          if (!loop_ok) begin
            match_q <= 4'h0;
          end else if (match_q >= pll_synth_pkg::LOCK_MATCHES - 4'h1) begin
            lock_state_q <= pll_synth_pkg::ST_LOCKED;
          end else begin
            match_q <= match_q + 4'h1;
          end
        end
        pll_synth_pkg::ST_LOCKED: begin
          if (!loop_ok) begin
            lock_state_q <= pll_synth_pkg::ST_ACQUIRE;
            match_q <= 4'h0;
          end
        end
        default: lock_state_q <= pll_synth_pkg::ST_UNLOCKED;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= run && (lock_state_q == pll_synth_pkg::ST_LOCKED);
    end
  end

  assign locked = locked_q;
  assign status_word = {settings_bad, ~run, ref_stopped, locked_q};

  // ----------------------------------------------------------------------
  // oscillator model and post-divider
  // ----------------------------------------------------------------------
  logic [15:0] acc_q;
  logic [16:0] acc_sum;
  logic vco_tick;
  logic [3:0] odiv_q;
  logic post_tick;

  // mult ticks per measured comparison period; one tick per pclk at most
  assign acc_sum = {1'b0, acc_q} + {9'h000, mult};
  assign vco_tick = run && (period_q != 16'h0000) &&
                    (acc_sum >= {1'b0, period_q});
  assign post_tick = vco_tick && (odiv_q >= o_eff - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 16'h0000;
    end else if (!run || period_q == 16'h0000) begin
      acc_q <= 16'h0000;
    end else if (vco_tick) begin
      acc_q <= 16'(acc_sum - {1'b0, period_q});
    end else begin
      acc_q <= acc_sum[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odiv_q <= 4'h0;
    end else if (!run || post_tick) begin
      odiv_q <= 4'h0;
    end else if (vco_tick) begin
      odiv_q <= odiv_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // output dividers with phase shift, counted in half post ticks
  // ----------------------------------------------------------------------
  function automatic logic [9:0] phase_off(input logic [8:0] c,
                                           input logic [2:0] ph);
    logic [9:0] off;
    off = 10'h000;
    case (c)
      9'h002: begin
        case (ph)
          pll_synth_pkg::PH_90: off = 10'h001;
          pll_synth_pkg::PH_180: off = 10'h002;
          pll_synth_pkg::PH_270: off = 10'h003;
          default: off = 10'h000;
        endcase
      end
      9'h004: begin
        case (ph)
          pll_synth_pkg::PH_45: off = 10'h001;
          pll_synth_pkg::PH_90: off = 10'h002;
          pll_synth_pkg::PH_135: off = 10'h003;
          default: off = 10'h000;
        endcase
      end
      9'h006: off = (ph == pll_synth_pkg::PH_90) ? 10'h003 : 10'h000;
      default: off = 10'h000;
    endcase
    return off;
  endfunction

  logic [2:0] clk_out_q;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_out
      logic [9:0] cnt_q;
      logic [9:0] span;
      logic [9:0] step;
      logic [9:0] shifted;
      logic [9:0] off;
      assign span = {c_eff[gi], 1'b0};
      assign off = phase_off(c_eff[gi],
                     outdiv_q[gi][pll_synth_pkg::OUTDIV_PH_LSB +: 3]);
      assign step = (cnt_q + 10'h002 >= span) ? 10'(cnt_q + 10'h002 - span) :
                    10'(cnt_q + 10'h002);
      assign shifted = (cnt_q + off >= span) ? 10'(cnt_q + off - span) :
                       10'(cnt_q + off);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= 10'h000;
        end else if (!run) begin
          cnt_q <= 10'h000;
        end else if (post_tick) begin
          cnt_q <= step;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clk_out_q[gi] <= 1'b0;
        end else if (!run || !out_en[gi]) begin
          clk_out_q[gi] <= 1'b0;
        end else if (c_eff[gi] == 9'h001) begin
          if (post_tick) begin
            clk_out_q[gi] <= ~clk_out_q[gi];
          end
        end else begin
          clk_out_q[gi] <= shifted < {1'b0, c_eff[gi]};
        end
      end
    end
  endgenerate

  assign synth_out_clk_a = clk_out_q[0];
  assign synth_out_clk_b = clk_out_q[1];
  assign synth_out_clk_c = clk_out_q[2];

endmodule

// [src/pll_synth_pkg.sv]
// constants, register map and state types of the clock synthesizer control
package pll_synth_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_OUTDIV_A = 8'h08;
  localparam logic [7:0] ADDR_OUTDIV_B = 8'h0C;
  localparam logic [7:0] ADDR_OUTDIV_C = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_PERIOD = 8'h18;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_FB_LSB = 2;
  localparam int CTRL_EN_LSB = 4;
  localparam int DIV_M_LSB = 0;
  localparam int DIV_N_LSB = 8;
  localparam int DIV_O_LSB = 12;
  localparam int OUTDIV_C_LSB = 0;
  localparam int OUTDIV_PH_LSB = 12;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
  localparam logic [31:0] DIV_RESET = 32'h0000_0101;
  localparam logic [31:0] OUTDIV_RESET = 32'h0000_0001;

  // ----------------------------------------------------------------------
  // modes and codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_EXTERNAL = 2'b00,
    SRC_DYNAMIC = 2'b01,
    SRC_CORE = 2'b10
  } clock_source_type;

  typedef enum logic [1:0] {
    FB_INTERNAL = 2'b00,
    FB_LOCAL = 2'b01,
    FB_CORE = 2'b10
  } feedback_mode_type;

  typedef enum logic [1:0] {
    ST_UNLOCKED = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_LOCKED = 2'b10
  } lock_state_type;

  localparam logic [2:0] PH_45 = 3'h1;
  localparam logic [2:0] PH_90 = 3'h2;
  localparam logic [2:0] PH_135 = 3'h3;
  localparam logic [2:0] PH_180 = 3'h4;
  localparam logic [2:0] PH_270 = 3'h5;

  localparam logic [1:0] CORE_REF_INDEX = 2'h0;
  localparam logic [7:0] FEEDBACK_PRODUCT_MAX = 8'hFF;

  // ----------------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------------
  localparam logic [15:0] REF_STOP_CYCLES = 16'h0800;
  localparam logic [3:0] LOCK_MATCHES = 4'h4;

endpackage

// [verification/pll_synth_properties.sv]
// port assertions for the clock synthesizer control
`timescale 1ns/10ps
module pll_synth_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] ref_clk_in,
  input wire logic external_ref_pin,
  input wire logic synth_reset_n,
  input wire logic synth_out_clk_a,
  input wire logic synth_out_clk_b,
  input wire logic synth_out_clk_c,
  input wire logic locked
);
  logic [4:0] ref_q;
  logic [4:0] quiet_q;
  // counts cycles with every reference source frozen and reset released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 5'h00;
      quiet_q <= 5'h00;
    end else begin
      ref_q <= {external_ref_pin, ref_clk_in};
      if (!synth_reset_n || ref_q != {external_ref_pin, ref_clk_in})
        quiet_q <= 5'h00;
      else if (quiet_q != 5'h1F)
        quiet_q <= quiet_q + 5'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_first_access;
    psel && $rose(penable);
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  sequence s_held_reset;
    !synth_reset_n [*5];
  endsequence
  a_answer_one_wait: assert property (s_first_access |=> s_answer)
    else $error("access not answered after one wait state");
  a_ready_needs_req: assert property ($rose(pready) |-> psel && penable)
    else $error("ready without a request");
  a_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  a_data_holds: assert property (!pready |-> $stable(prdata))
    else $error("read data moved outside an answer");
  a_reset_clears_lock: assert property (s_held_reset |-> !locked)
    else $error("lock high while held in reset");
  a_reset_stops_outs: assert property (
    s_held_reset |-> !(synth_out_clk_a || synth_out_clk_b || synth_out_clk_c))
    else $error("output clock running in reset");
  a_lock_after_run: assert property (
    $rose(locked) |-> $past(synth_reset_n, 4))
    else $error("lock rose too soon after reset");
  a_lock_drop_reset: assert property (
    $fell(synth_reset_n) |-> ##[0:5] !locked)
    else $error("lock not cleared by reset");
  a_lock_holds_quiet: assert property (
    quiet_q >= 5'h10 |-> $stable(locked))
    else $error("lock changed with reference stopped");
endmodule

bind pll_clock_synthesizer_control pll_synth_properties i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ref_clk_in(ref_clk_in), .external_ref_pin(external_ref_pin),
  .synth_reset_n(synth_reset_n), .synth_out_clk_a(synth_out_clk_a),
  .synth_out_clk_b(synth_out_clk_b), .synth_out_clk_c(synth_out_clk_c),
  .locked(locked));

// [verification/fabric_model.sv]
// fabric side model: synthesizer reset, reference select and feedback
`timescale 1ns/10ps
module fabric_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_reset,
  input wire logic [1:0] req_select,
  input wire logic synth_out_clk_a,
  output logic synth_reset_n,
  output logic [1:0] ref_select,
  output logic fabric_feedback_clk
);
  logic [2:0] hold_q;
  // select only moves once reset is already low; release after a hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_reset_n <= 1'h0;
      ref_select <= 2'h0;
      hold_q <= 3'h4;
    end else if (req_reset || req_select != ref_select) begin
      synth_reset_n <= 1'h0;
      hold_q <= 3'h4;
      if (!synth_reset_n) ref_select <= req_select;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else begin
      synth_reset_n <= 1'h1;
    end
  end
  // one synthesizer only, output a routed back as core feedback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fabric_feedback_clk <= 1'h0;
    else fabric_feedback_clk <= synth_out_clk_a;
  end
endmodule

// [verification/test_pll_clock_synthesizer_control.sv]
// self-checking bench for the clock synthesizer control
`timescale 1ns/10ps
module test_pll_clock_synthesizer_control;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, locked, synth_reset_n, fb_clk;
  logic [2:0] outs;
  logic [1:0] ref_select;
  logic req_reset = 1'h0;
  logic [1:0] req_select = 2'h0;
  logic [4:0] rsrc = 5'h00;
  logic [4:0] on = 5'h00;
  int half [5] = '{8, 10, 12, 14, 8};
  int cnt [5] = '{0, 0, 0, 0, 0};
  int failures = 0;
  int tests_run = 0;
  int p;

  always #5 pclk = ~pclk;
  // reference sources, index 4 is the external pin
  always @(posedge pclk) begin
    for (int i = 0; i < 5; i++) begin
      if (on[i]) begin
        cnt[i] <= (cnt[i] >= half[i] - 1) ? 0 : cnt[i] + 1;
        if (cnt[i] >= half[i] - 1) rsrc[i] <= ~rsrc[i];
      end
    end
  end

  pll_clock_synthesizer_control i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clk_in(rsrc[3:0]), .external_ref_pin(rsrc[4]),
    .ref_select(ref_select), .synth_reset_n(synth_reset_n),
    .fabric_feedback_clk(fb_clk), .synth_out_clk_a(outs[0]),
    .synth_out_clk_b(outs[1]), .synth_out_clk_c(outs[2]), .locked(locked));
  fabric_model i_fabric (.pclk(pclk), .presetn(presetn),
    .req_reset(req_reset), .req_select(req_select),
    .synth_out_clk_a(outs[0]), .synth_reset_n(synth_reset_n),
    .ref_select(ref_select), .fabric_feedback_clk(fb_clk));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // period counts may land one cycle either side
  task automatic near(input logic [31:0] got, input int exp);
    tests_run++;
    if (got !== exp && got !== exp + 1 && got !== exp - 1) begin
      failures++;
      $display("[ERR] %0t period %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 40) chk(1'h0, 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_lock(input logic exp);
    int n;
    for (n = 0; n < 3000 && locked !== exp; n++) @(posedge pclk);
    chk(locked, exp);
  endtask
  task automatic relock(input logic [1:0] k);
    @(posedge pclk);
    req_select <= k;
    req_reset <= 1'h1;
    @(posedge pclk);
    req_reset <= 1'h0;
    wait_lock(1'h0);
    wait_lock(1'h1);
  endtask
  task automatic period_of(input int idx);
    int n, e;
    logic last;
    e = 0;
    last = 1'h1;
    for (n = 0; n < 4000 && e < 2; n++) begin
      @(posedge pclk);
      if (outs[idx] === 1'h1 && last === 1'h0) begin
        p = (e == 0) ? n : n - p;
        e++;
      end
      last = outs[idx];
    end
    if (e < 2) p = 0;
  endtask

  task automatic t_registers();
    apb(1'h0, pll_synth_pkg::ADDR_CTRL, 32'h0);
    chk(rd, pll_synth_pkg::CTRL_RESET);
    apb(1'h0, pll_synth_pkg::ADDR_DIV, 32'h0);
    chk(rd, pll_synth_pkg::DIV_RESET);
    apb(1'h0, pll_synth_pkg::ADDR_OUTDIV_C, 32'h0);
    chk(rd, pll_synth_pkg::OUTDIV_RESET);
    apb(1'h1, 8'h1C, 32'hFFFF_FFFF);
    chk(err, 1'h1);
    apb(1'h0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'h1);
  endtask
  task automatic t_select();
    apb(1'h1, pll_synth_pkg::ADDR_DIV, 32'h0000_0202);
    apb(1'h1, pll_synth_pkg::ADDR_OUTDIV_A, 32'h0000_0002);
    for (int k = 0; k < 4; k++) begin
      on <= 5'h01 << k;
      relock(2'(k));
      apb(1'h0, pll_synth_pkg::ADDR_PERIOD, 32'h0);
      near(rd, 32 + 8 * k);
      period_of(0);
      near(p, 32 + 8 * k);
    end
  endtask
  task automatic t_feedback();
    on <= 5'h01;
    apb(1'h1, pll_synth_pkg::ADDR_CTRL, 32'h0000_0015);
    apb(1'h1, pll_synth_pkg::ADDR_DIV, 32'h0000_1202);
    relock(2'h0);
    period_of(0);
    near(p, 16);
    apb(1'h1, pll_synth_pkg::ADDR_CTRL, 32'h0000_0019);
    relock(2'h0);
    period_of(0);
    near(p, 16);
    apb(1'h1, pll_synth_pkg::ADDR_DIV, 32'h0000_12C8);
    apb(1'h0, pll_synth_pkg::ADDR_STATUS, 32'h0);
    chk(rd[3], 1'h1);
    apb(1'h1, pll_synth_pkg::ADDR_CTRL, 32'h0000_0071);
    apb(1'h1, pll_synth_pkg::ADDR_DIV, 32'h0000_0202);
    apb(1'h1, pll_synth_pkg::ADDR_OUTDIV_B, 32'h0000_0002);
    apb(1'h1, pll_synth_pkg::ADDR_OUTDIV_C, 32'h0000_2004);
    relock(2'h0);
    period_of(1);
    near(p, 64);
    period_of(2);
    near(p, 128);
    chk(outs[1], 1'h0);
  endtask
  task automatic t_lock_hold();
    apb(1'h1, pll_synth_pkg::ADDR_CTRL, 32'h0000_0011);
    relock(2'h0);
    on <= 5'h00;
    repeat (2500) @(posedge pclk);
    chk(locked, 1'h1);
    apb(1'h0, pll_synth_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1:0], 2'h3);
    on <= 5'h01;
    half[0] <= 12;
    wait_lock(1'h0);
    wait_lock(1'h1);
    half[0] <= 8;
  endtask
  task automatic t_sources();
    on <= 5'h10;
    apb(1'h1, pll_synth_pkg::ADDR_CTRL, 32'h0000_0010);
    relock(2'h1);
    apb(1'h0, pll_synth_pkg::ADDR_PERIOD, 32'h0);
    near(rd, 32);
    on <= 5'h01;
    apb(1'h1, pll_synth_pkg::ADDR_CTRL, 32'h0000_0012);
    relock(2'h3);
    apb(1'h0, pll_synth_pkg::ADDR_PERIOD, 32'h0);
    near(rd, 32);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    chk(1'h0, 1'h1);
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_registers();
    t_select();
    t_feedback();
    t_lock_hold();
    t_sources();
    tally_and_finish();
  end
endmodule
